// ### rtl/stp_drive.sv
// Purpose: Drive end of the streaming tape host port.
// Assumes: Cable inputs are asynchronous and pass two flops.
// Notes:   Tape channel is abstracted to a serial bit port.
`timescale 1ns/1ps
module stp_drive
  import stp_pkg::*;
#(
  parameter int unsigned TAPE_BLOCKS = stp_pkg::TAPE_LEN
)(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  stp_if.drive                       cab,
  input  wire logic [ADDR_W-1:0]     addr_sw_i,
  input  wire logic                  tape_bit_i,
  input  wire logic                  raw_weak_i,
  input  wire logic                  raw_late_i,
  input  wire logic                  hard_err_i,
  output logic                       tape_bit_o,
  output logic                       tape_fwd_o,
  output logic                       tape_rev_o,
  output logic                       head_lower_o,
  output logic                       head_upper_o,
  output logic                       erase_head_o,
  output logic [TRACK_W-1:0]         track_o,
  output logic [6:0]                 read_gain_pct_o,
  output logic [4:0]                 win_width_o
);
  import stp_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_CMD = 3'b001, D_STAT = 3'b011,
    D_WDAT = 3'b010, D_RDAT = 3'b110, D_ERASE = 3'b111,
    D_HOLD = 3'b101
  } stp_dstate_t;

  typedef struct packed {
    logic [1:0]           s_xfer, s_req, s_onl, s_rst;
    logic [7:0]           s_bus0, s_bus1;
    stp_dstate_t          st;
    logic                 selected;
    logic                 ack_n, rdy_n, exc_n, dir_n;
    logic [7:0]           bus_out;
    logic                 bus_oe;
    logic [7:0]           status;
    logic [BUF_SEL_W-1:0] host_buf, tape_buf;
    logic [BUF_IDX_W-1:0] host_idx, tape_idx;
    logic [2:0]           bit_idx;
    logic [BUF_COUNT-1:0] full;
    logic                 fwd, rev, erasing;
    logic [TRACK_W-1:0]   track;
    logic [POS_W-1:0]     pos;
    logic                 writing;
    logic                 tbit;
    logic [7:0]           rd_shift;
  } stp_drive_state_t;

  stp_drive_state_t q, d;
  logic [7:0] mem_q [BUF_COUNT*BUF_BYTES];
  logic       mem_we;
  logic [10:0] mem_wa;
  logic [7:0]  mem_wd;

  // ************************************************************
  // Synchronised cable inputs, true when line is low
  // ************************************************************
  logic xfer, req, onl, hrst;
  logic [7:0] bus_in;
  assign xfer   = ~q.s_xfer[1];
  assign req    = ~q.s_req[1];
  assign onl    = ~q.s_onl[1];
  assign hrst   = ~q.s_rst[1];
  assign bus_in = ~q.s_bus1;

  function automatic logic [10:0] maddr(logic [BUF_SEL_W-1:0] b,
                                        logic [BUF_IDX_W-1:0] i);
    maddr = 11'(b) * 11'(BUF_BYTES) + 11'(i);
  endfunction

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    d = q;
    mem_we = 1'b0;
    mem_wa = maddr(q.host_buf, q.host_idx);
    mem_wd = bus_in;
    d.s_xfer = {q.s_xfer[0], cab.xfer_n};
    d.s_req  = {q.s_req[0], cab.req_n};
    d.s_onl  = {q.s_onl[0], cab.host_session_active_n};
    d.s_rst  = {q.s_rst[0], cab.reset_n};
    d.s_bus0 = cab.bus_n;
    d.s_bus1 = q.s_bus0;
    if (hard_err_i)
      d.status[ST_HARD_ERR] = 1'b1;
    d.exc_n = ~(q.selected & q.status[ST_HARD_ERR]);
    case (q.st)
      D_IDLE:
      begin
        // Ready stays on while idle, so an unselected drive can still be
        // addressed; only a matching select makes it answer.
        d.rdy_n = 1'b0;
        if (req && q.dir_n)
        begin
          if ((bus_in & CMD_SEL_MASK) == CMD_SELECT_BASE)
          begin
            d.selected = (bus_in[ADDR_W-1:0] == addr_sw_i);
            d.status[ST_SELECTED] = d.selected;
          end
          if (q.selected || d.selected)
          begin
            d.rdy_n = 1'b1;
            d.st    = D_CMD;
            if (q.selected && bus_in == CMD_READ_STATUS)
            begin
              d.st = D_STAT;
              d.dir_n = 1'b0;
              d.bus_out = ~q.status;
            end
            else if (q.selected && bus_in == CMD_WRITE)
            begin
              d.writing = 1'b1;
              d.fwd = 1'b1;
              d.host_idx = '0;
            end
            else if (q.selected && bus_in == CMD_READ)
            begin
              d.writing = 1'b0;
              d.fwd = 1'b1;
              d.dir_n = 1'b0;
              d.host_idx = '0;
            end
            else if (q.selected && bus_in == CMD_ERASE)
            begin
              d.erasing = 1'b1;
              d.fwd = 1'b1;
            end
            else if (q.selected && bus_in == CMD_REWIND)
            begin
              d.rev = 1'b1;
              d.fwd = 1'b0;
            end
            else if (q.selected &&
                     (bus_in & CMD_TRACK_MASK) == CMD_TRACK_BASE)
              d.track = bus_in[TRACK_W-1:0];
          end
        end
      end
      D_CMD:
        if (!req)
        begin
          d.rdy_n = 1'b0;
          d.st = q.erasing ? D_ERASE :
                 (q.fwd && onl) ? (q.writing ? D_WDAT : D_RDAT) : D_IDLE;
        end
      D_STAT:
      begin
        // The byte goes out only once the host has let go of the bus.
        if (!req && q.rdy_n)
        begin
          d.rdy_n  = 1'b0;
          d.bus_oe = 1'b1;
        end
        else if (req && !q.rdy_n)
        begin
          d.rdy_n = 1'b1;
          d.st = D_HOLD;
          d.status[ST_HARD_ERR] = hard_err_i;
          d.status[ST_REWRITE] = 1'b0;
        end
      end
      D_HOLD:
        if (!req)
        begin
          d.bus_oe = 1'b0;
          d.dir_n = 1'b1;
          d.st = D_IDLE;
        end
      D_WDAT:
      begin
        if (xfer && q.ack_n && !q.full[q.host_buf])
        begin
          mem_we = 1'b1;
          d.ack_n = 1'b0;
          d.host_idx = q.host_idx + 1'b1;
          if (q.host_idx == BUF_IDX_W'(BUF_BYTES-1))
          begin
            d.full[q.host_buf] = 1'b1;
            d.host_buf = (q.host_buf == BUF_SEL_W'(BUF_COUNT-1)) ?
                         '0 : q.host_buf + 1'b1;
          end
        end
        else if (!xfer)
          d.ack_n = 1'b1;
        if (!onl)
          d.st = D_IDLE;
      end
      D_RDAT:
      begin
        if (xfer && !q.ack_n)
          d.ack_n = 1'b0;
        else if (!xfer && !q.ack_n)
        begin
          d.ack_n = 1'b1;
          d.host_idx = q.host_idx + 1'b1;
          if (q.host_idx == BUF_IDX_W'(BUF_BYTES-1))
          begin
            d.full[q.host_buf] = 1'b0;
            d.host_buf = (q.host_buf == BUF_SEL_W'(BUF_COUNT-1)) ?
                         '0 : q.host_buf + 1'b1;
          end
        end
        else if (xfer && q.ack_n && q.full[q.host_buf])
        begin
          d.bus_out = ~mem_q[maddr(q.host_buf, q.host_idx)];
          d.bus_oe = 1'b1;
          d.ack_n = 1'b0;
        end
        if (!onl)
        begin
          d.st = D_IDLE;
          d.bus_oe = 1'b0;
          d.dir_n = 1'b1;
        end
      end
      D_ERASE:
        if (q.pos == POS_W'(TAPE_BLOCKS-1))
        begin
          d.erasing = 1'b0;
          d.rev = 1'b1;
          d.st = D_IDLE;
        end
      default: d.st = D_IDLE;
    endcase

    // Tape side serialiser: one bit per clock from or to the buffers.
    if (q.fwd && q.writing && q.full[q.tape_buf])
    begin
      d.tbit = mem_q[maddr(q.tape_buf, q.tape_idx)][q.bit_idx];
      d.bit_idx = q.bit_idx + 1'b1;
      if (q.bit_idx == 3'h7)
        d.tape_idx = q.tape_idx + 1'b1;
      if (q.bit_idx == 3'h7 && q.tape_idx == BUF_IDX_W'(BUF_BYTES-1))
      begin
        if (raw_weak_i || raw_late_i)
        begin
          d.status[ST_REWRITE] = 1'b1;
        end
        else
        begin
          d.full[q.tape_buf] = 1'b0;
          d.tape_buf = (q.tape_buf == BUF_SEL_W'(BUF_COUNT-1)) ?
                       '0 : q.tape_buf + 1'b1;
        end
      end
    end
    else if (q.fwd && !q.writing && !q.erasing && !q.full[q.tape_buf]
             && q.st == D_RDAT)
    begin
      d.rd_shift = {tape_bit_i, q.rd_shift[7:1]};
      d.bit_idx  = q.bit_idx + 1'b1;
      mem_we     = (q.bit_idx == 3'h7);
      mem_wa     = maddr(q.tape_buf, q.tape_idx);
      mem_wd     = d.rd_shift;
      if (q.bit_idx == 3'h7)
        d.tape_idx = q.tape_idx + 1'b1;
      if (q.bit_idx == 3'h7 && q.tape_idx == BUF_IDX_W'(BUF_BYTES-1))
      begin
        d.full[q.tape_buf] = 1'b1;
        d.tape_buf = (q.tape_buf == BUF_SEL_W'(BUF_COUNT-1)) ?
                     '0 : q.tape_buf + 1'b1;
      end
    end

    // End-of-tape interlocks stop motion at either end.
    if (q.fwd && q.pos != POS_W'(TAPE_BLOCKS-1))
      d.pos = q.pos + 1'b1;
    else if (q.rev && q.pos != '0)
      d.pos = q.pos - 1'b1;
    if (q.fwd && q.pos == POS_W'(TAPE_BLOCKS-1))
      d.fwd = 1'b0;
    if (q.rev && q.pos == '0)
      d.rev = 1'b0;
    d.status[ST_BOT] = (d.pos == '0);
    d.status[ST_EOT] = (d.pos == POS_W'(TAPE_BLOCKS-1));
    if (hrst)
      d = '{s_xfer: q.s_xfer, s_req: q.s_req, s_onl: q.s_onl,
            s_rst: q.s_rst, s_bus0: q.s_bus0, s_bus1: q.s_bus1,
            st: D_IDLE, ack_n: 1'b1, rdy_n: 1'b1, exc_n: 1'b1,
            dir_n: 1'b1, bus_out: 8'hFF, default: '0};
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= '{s_xfer: 2'h3, s_req: 2'h3, s_onl: 2'h3, s_rst: 2'h3,
             s_bus0: 8'hFF, s_bus1: 8'hFF, st: D_IDLE, ack_n: 1'b1,
             rdy_n: 1'b1, exc_n: 1'b1, dir_n: 1'b1, bus_out: 8'hFF,
             default: '0};
    else
      q <= d;
  end

  always_ff @(posedge clk_i)
  begin
    if (mem_we)
      mem_q[mem_wa] <= mem_wd;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign cab.bus_drv_o          = q.bus_out;
  assign cab.bus_drv_oe         = q.bus_oe;
  assign cab.drive_data_ack_n   = q.ack_n;
  assign cab.ready_n            = q.rdy_n;
  assign cab.drive_fault_flag_n = q.exc_n;
  assign cab.dir_n              = q.dir_n;
  assign tape_bit_o      = q.tbit;
  assign tape_fwd_o      = q.fwd;
  assign tape_rev_o      = q.rev;
  assign head_lower_o    = q.fwd;
  assign head_upper_o    = q.rev;
  assign erase_head_o    = q.erasing |
                           (q.writing & q.fwd & (q.track == '0));
  assign track_o         = q.track;
  assign read_gain_pct_o = q.writing ? 7'(100 - RAW_ATTEN_PCT) : 7'd100;
  assign win_width_o     = q.writing ? 5'(WIN_RAW) : 5'(WIN_NOM);
endmodule // stp_drive

// ### rtl/stp_host.sv
// Purpose: Host adapter end of the streaming tape host port.
// Assumes: Drive lines are asynchronous and pass two flops.
// Notes:   One request at a time from the user side.
`timescale 1ns/1ps
module stp_host
  import stp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  stp_if.host             cab,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_i,
  input  wire logic       stat_rd_i,
  input  wire logic       dat_valid_i,
  input  wire logic [7:0] dat_i,
  input  wire logic       dat_rd_i,
  input  wire logic       host_session_active_n_i,
  input  wire logic       drive_reset_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rdata_o,
  output logic            fault_o
);
  import stp_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_REQ = 3'b001, H_REL = 3'b011,
    H_XFR = 3'b010, H_XREL = 3'b110
  } stp_hstate_t;

  typedef struct packed {
    logic [1:0]  s_ack, s_rdy, s_exc, s_dir;
    logic [7:0]  s_bus0, s_bus1;
    stp_hstate_t st;
    logic        req_n, xfer_n, onl_n, rst_n, oe, rd;
    logic [7:0]  out;
    logic        busy, done, fault;
    logic [7:0]  rdata;
  } stp_host_state_t;

  stp_host_state_t q, d;
  logic ack, rdy, exc, dirdev;
  assign ack    = ~q.s_ack[1];
  assign rdy    = ~q.s_rdy[1];
  assign exc    = ~q.s_exc[1];
  assign dirdev = ~q.s_dir[1];

  always_comb
  begin
    d = q;
    d.s_ack = {q.s_ack[0], cab.drive_data_ack_n};
    d.s_rdy = {q.s_rdy[0], cab.ready_n};
    d.s_exc = {q.s_exc[0], cab.drive_fault_flag_n};
    d.s_dir = {q.s_dir[0], cab.dir_n};
    d.s_bus0 = cab.bus_n;
    d.s_bus1 = q.s_bus0;
    d.onl_n = ~host_session_active_n_i;
    d.rst_n = ~drive_reset_i;
    d.fault = exc;
    d.done = 1'b0;
    d.oe = ~dirdev & q.oe;
    case (q.st)
      H_IDLE:
        if ((cmd_valid_i || stat_rd_i) && (rdy || exc))
        begin
          d.out = ~cmd_i;
          d.oe = ~dirdev;
          d.req_n = 1'b0;
          d.rd = stat_rd_i;
          d.busy = 1'b1;
          d.st = H_REQ;
        end
        else if ((dat_valid_i || dat_rd_i) && rdy && host_session_active_n_i)
        begin
          d.out = ~dat_i;
          d.oe = dat_valid_i & ~dirdev;
          d.xfer_n = 1'b0;
          d.rd = dat_rd_i;
          d.busy = 1'b1;
          d.st = H_XFR;
        end
      H_REQ:
        if (!rdy)
        begin
          d.req_n = 1'b1;
          d.st = H_REL;
        end
      H_REL:
        if (rdy && q.rd)
        begin
          d.rdata = ~q.s_bus1;
          d.req_n = 1'b0;
          d.rd = 1'b0;
          d.st = H_REQ;
        end
        else if (!q.rd)
        begin
          d.oe = 1'b0;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = H_IDLE;
        end
      H_XFR:
        if (ack)
        begin
          if (q.rd)
            d.rdata = ~q.s_bus1;
          d.xfer_n = 1'b1;
          d.st = H_XREL;
        end
      H_XREL:
        if (!ack)
        begin
          d.oe = 1'b0;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = H_IDLE;
        end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= '{s_ack: 2'h3, s_rdy: 2'h3, s_exc: 2'h3, s_dir: 2'h3,
             s_bus0: 8'hFF, s_bus1: 8'hFF, st: H_IDLE, req_n: 1'b1,
             xfer_n: 1'b1, onl_n: 1'b1, rst_n: 1'b1, out: 8'hFF,
             default: '0};
    else
      q <= d;
  end

  assign cab.bus_host_o           = q.out;
  assign cab.bus_host_oe          = q.oe;
  assign cab.req_n                = q.req_n;
  assign cab.xfer_n               = q.xfer_n;
  assign cab.host_session_active_n = q.onl_n;
  assign cab.reset_n              = q.rst_n;
  assign busy_o  = q.busy;
  assign done_o  = q.done;
  assign rdata_o = q.rdata;
  assign fault_o = q.fault;
endmodule // stp_host

// ### rtl/stp_if.sv
// Purpose: Carrier of the host-to-drive cable signals.
// Assumes: Active-low lines, one wire value per line.
// Notes:   Bus level is worked out from both output enables.
`timescale 1ns/1ps
interface stp_if;
  logic [7:0] bus_drv_o;
  logic       bus_drv_oe;
  logic [7:0] bus_host_o;
  logic       bus_host_oe;
  logic [7:0] bus_n;
  logic       xfer_n;
  logic       req_n;
  logic       host_session_active_n;
  logic       reset_n;
  logic       drive_data_ack_n;
  logic       ready_n;
  logic       drive_fault_flag_n;
  logic       dir_n;

  // Low-active wired bus: released lines float high.
  assign bus_n = bus_drv_oe ? bus_drv_o :
                 (bus_host_oe ? bus_host_o : 8'hFF);

  modport drive (input bus_n, xfer_n, req_n, host_session_active_n,
                 reset_n, output bus_drv_o, bus_drv_oe,
                 drive_data_ack_n, ready_n, drive_fault_flag_n, dir_n);
  modport host  (input bus_n, drive_data_ack_n, ready_n,
                 drive_fault_flag_n, dir_n, output bus_host_o,
                 bus_host_oe, xfer_n, req_n, host_session_active_n,
                 reset_n);
endinterface // stp_if

// ### rtl/stp_pkg.sv
// Purpose: Shared constants for the tape drive host port.
// Assumes: 100 MHz clock, eight-line active-low shared bus.
// Notes:   Both ends import this package.
package stp_pkg;
  // ************************************************************
  // Bus and addressing
  // ************************************************************
  localparam int unsigned BUS_W        = 8;
  localparam int unsigned ADDR_W       = 2;
  localparam int unsigned MAX_DRIVES   = 4;
  localparam int unsigned BUF_BYTES    = 512;
  localparam int unsigned BUF_COUNT    = 3;
  localparam int unsigned BUF_IDX_W    = 9;
  localparam int unsigned BUF_SEL_W    = 2;
  localparam int unsigned TRACK_W      = 2;

  // ************************************************************
  // Command codes and status bits (values of our own choosing)
  // ************************************************************
  localparam logic [7:0] CMD_SELECT_BASE = 8'h00;
  localparam logic [7:0] CMD_SEL_MASK    = 8'hFC;
  localparam logic [7:0] CMD_READ_STATUS = 8'hC0;
  localparam logic [7:0] CMD_WRITE       = 8'h40;
  localparam logic [7:0] CMD_READ        = 8'h80;
  localparam logic [7:0] CMD_ERASE       = 8'h22;
  localparam logic [7:0] CMD_REWIND      = 8'h21;
  localparam logic [7:0] CMD_TRACK_BASE  = 8'h10;
  localparam logic [7:0] CMD_TRACK_MASK  = 8'hFC;
  localparam logic [7:0] STAT_RESET_VAL  = 8'h00;
  localparam int unsigned ST_BOT         = 0;
  localparam int unsigned ST_EOT         = 1;
  localparam int unsigned ST_HARD_ERR    = 2;
  localparam int unsigned ST_REWRITE     = 3;
  localparam int unsigned ST_SELECTED    = 4;

  // ************************************************************
  // Read-after-write margins and timing
  // ************************************************************
  localparam int unsigned RAW_ATTEN_PCT  = 75;
  localparam int unsigned RAW_WIN_SHRINK = 25;
  localparam int unsigned WIN_NOM        = 16;
  localparam int unsigned WIN_RAW        =
    WIN_NOM - (WIN_NOM * RAW_WIN_SHRINK) / 100;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned BURST_KBPS     = 200;
  localparam int unsigned BYTE_NS        = 1000000 / BURST_KBPS;
  localparam int unsigned BYTE_CYC       = BYTE_NS * CLK_MHZ / 1000;
  localparam int unsigned TAPE_LEN       = 4096;
  localparam int unsigned POS_W          = 16;
endpackage

// ### tb/stp_asserts.sv
// Purpose: Cable checks for the tape host port.
// Assumes: One clock; rst_i is high while reset.
// Notes:   Watches the signals carried between the two ends.
`timescale 1ns/1ps
module stp_asserts (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] bus_n,
  input  wire logic       bus_drv_oe,
  input  wire logic       bus_host_oe,
  input  wire logic       xfer_n,
  input  wire logic       req_n,
  input  wire logic       drive_data_ack_n,
  input  wire logic       ready_n,
  input  wire logic       dir_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ************************************************************
  // Bus ownership and handshakes
  // ************************************************************
  chk_one_bus_owner: assert property (
    !(bus_drv_oe && bus_host_oe)) else $error("both ends drive the bus");
  chk_drive_owns_dir: assert property (
    bus_drv_oe |-> !dir_n) else $error("drive drives bus without dir");
  chk_host_gone_dir: assert property (
    $fell(dir_n) |-> ##3 !bus_host_oe) else $error("host still drives bus");
  chk_ack_needs_xfer: assert property (
    $fell(drive_data_ack_n) |-> !xfer_n) else $error("ack without strobe");
  chk_ack_held: assert property (
    (!drive_data_ack_n && !xfer_n) |=> !drive_data_ack_n)
    else $error("ack dropped while strobe held");
  chk_req_held: assert property (
    (!req_n && !ready_n) |=> !req_n) else $error("request dropped early");
  chk_xfer_held: assert property (
    (!xfer_n && drive_data_ack_n) |=> !xfer_n)
    else $error("strobe dropped before ack");
  chk_ack_release: assert property (
    $rose(xfer_n) |-> ##[1:10] drive_data_ack_n)
    else $error("ack not released after strobe");
  chk_cmd_bus_steady: assert property (
    (!req_n && $past(!req_n) && bus_host_oe && $past(bus_host_oe))
    |-> $stable(bus_n)) else $error("command byte moved under request");
  cover property ($fell(drive_data_ack_n));
  cover property ($rose(ready_n));
  cover property (bus_drv_oe);
endmodule // stp_asserts

// ### tb/testbench.sv
// Purpose: Joins both ends and drives their user sides.
// Assumes: 100 MHz clock; inputs change on the falling edge.
// Notes:   Tape is long enough for one buffer to reach it.
`timescale 1ns/1ps
module testbench;
  import stp_pkg::*;
  logic       clk_i, rst_i, cmd_valid_i, stat_rd_i, dat_valid_i;
  logic       dat_rd_i, host_session_active_n_i, drive_reset_i, busy_o, done_o;
  logic       fault_o, tape_bit_i, raw_weak_i, raw_late_i, hard_err_i;
  logic       tape_fwd_o, tape_rev_o, head_lower_o, head_upper_o;
  logic       erase_head_o;
  logic [7:0] cmd_i, dat_i, rdata_o, host_byte, drv_byte, d, sel;
  logic [1:0] addr_sw_i, track_o;
  logic [6:0] read_gain_pct_o;
  logic [4:0] win_width_o;
  int         mismatches, total_checks, cyc, n;
  stp_if cab_if();
  stp_host i_stp_host (.clk_i, .rst_i, .cab(cab_if), .cmd_valid_i,
    .cmd_i, .stat_rd_i, .dat_valid_i, .dat_i, .dat_rd_i, .host_session_active_n_i,
    .drive_reset_i, .busy_o, .done_o, .rdata_o, .fault_o);
  stp_drive #(.TAPE_BLOCKS(16384)) i_stp_drive (.clk_i, .rst_i,
    .cab(cab_if), .addr_sw_i, .tape_bit_i, .raw_weak_i, .raw_late_i,
    .hard_err_i, .tape_bit_o(), .tape_fwd_o, .tape_rev_o, .head_lower_o,
    .head_upper_o, .erase_head_o, .track_o, .read_gain_pct_o,
    .win_width_o);
  stp_asserts i_stp_asserts (.clk_i, .rst_i, .bus_n(cab_if.bus_n),
    .bus_drv_oe(cab_if.bus_drv_oe), .bus_host_oe(cab_if.bus_host_oe),
    .xfer_n(cab_if.xfer_n), .req_n(cab_if.req_n), .dir_n(cab_if.dir_n),
    .drive_data_ack_n(cab_if.drive_data_ack_n), .ready_n(cab_if.ready_n));
  // ************************************************************
  // Clock, timeout and wire monitor
  // ************************************************************
  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      mismatches++;
      conclude();
    end
  end
  always @(negedge clk_i)
  begin
    tape_bit_i = 1'($urandom);
    if (cab_if.bus_host_oe) host_byte = cab_if.bus_n;
    if (cab_if.bus_drv_oe) drv_byte = cab_if.bus_n;
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] on_wire(logic [7:0] v);
    return ~v;
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_done();
    n = 0;
    while (done_o !== 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    check("done", 16'(done_o), 16'h0001);
  endtask
  task automatic send(logic [7:0] c, logic st);
    @(negedge clk_i);
    cmd_i = c;
    cmd_valid_i = !st;
    stat_rd_i = st;
    // Hold the request until the adapter has taken it.
    n = 0;
    while (busy_o !== 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    cmd_valid_i = 0;
    stat_rd_i = 0;
    wait_done();
  endtask
  task automatic status();
    send(CMD_READ_STATUS, 1);
    check("status wire", rdata_o, on_wire(drv_byte));
  endtask
  task automatic wait_on(input bit erase, input int lim);
    n = 0;
    while ((erase ? erase_head_o : tape_rev_o) !== 1'b1 && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    {cmd_valid_i, stat_rd_i, dat_valid_i, dat_rd_i, host_session_active_n_i} = '0;
    {drive_reset_i, raw_weak_i, raw_late_i, hard_err_i} = '0;
    cmd_i = 8'h00;
    dat_i = 8'h00;
    rst_i = 1;
    void'($urandom(32'hE4B1));
    addr_sw_i = 2'($urandom_range(3, 0));
    repeat (20) @(negedge clk_i);
    check("idle bus", cab_if.bus_n, 8'hFF);
    check("idle lines", {cab_if.xfer_n, cab_if.req_n, cab_if.reset_n,
      cab_if.drive_data_ack_n, cab_if.ready_n, cab_if.dir_n}, 6'h3F);
    rst_i = 0;
    repeat (3) @(negedge clk_i);
    sel = CMD_SELECT_BASE | 8'(addr_sw_i);
    send(sel, 0);
    check("select wire", host_byte, on_wire(sel));
    status();
    check("selected", 16'(rdata_o[ST_SELECTED]), 16'h0001);
    $display("test select done");
    host_session_active_n_i = 1;
    raw_weak_i = 1;
    send(CMD_WRITE, 0);
    for (int i = 0; i < 520; i++)
    begin
      d = 8'($urandom);
      @(negedge clk_i);
      dat_i = d;
      dat_valid_i = 1;
      n = 0;
      while (busy_o !== 1'b1 && n < 100)
      begin
        @(negedge clk_i);
        n++;
      end
      dat_valid_i = 0;
      wait_done();
    end
    check("data wire", host_byte, on_wire(d));
    check("fwd heads", {tape_fwd_o, head_lower_o, head_upper_o}, 3'h6);
    check("erase t0", 16'(erase_head_o), 16'h0001);
    check("gain", 16'(read_gain_pct_o), 16'd25);
    check("window", 16'(win_width_o), 16'(WIN_RAW));
    host_session_active_n_i = 0;
    // A full buffer needs 4096 clocks to reach tape and be checked.
    repeat (4200) @(negedge clk_i);
    raw_weak_i = 0;
    status();
    check("rewrite", 16'(rdata_o[ST_REWRITE]), 16'h0001);
    $display("test write done");
    send(CMD_REWIND, 0);
    wait_on(1'b0, 200);
    check("rev heads", {head_lower_o, head_upper_o}, 2'h1);
    n = 0;
    while (tape_rev_o !== 1'b0 && n < 30000)
    begin
      @(negedge clk_i);
      n++;
    end
    check("stopped", 16'(tape_rev_o), 16'h0000);
    status();
    check("at bot", 16'(rdata_o[ST_BOT]), 16'h0001);
    $display("test rewind done");
    send(CMD_TRACK_BASE | 8'h01, 0);
    check("track", 16'(track_o), 16'h0001);
    check("no erase", 16'(erase_head_o), 16'h0000);
    host_session_active_n_i = 1;
    send(CMD_READ, 0);
    check("read gain", 16'(read_gain_pct_o), 16'd100);
    check("read window", 16'(win_width_o), 16'(WIN_NOM));
    check("read dir", 16'(cab_if.dir_n), 16'h0000);
    check("read heads", {head_lower_o, head_upper_o}, 2'h2);
    host_session_active_n_i = 0;
    repeat (10) @(negedge clk_i);
    check("dir back", 16'(cab_if.dir_n), 16'h0001);
    $display("test read mode done");
    @(negedge clk_i);
    hard_err_i = 1;
    @(negedge clk_i);
    hard_err_i = 0;
    repeat (10) @(negedge clk_i);
    check("fault line", 16'(cab_if.drive_fault_flag_n), 16'h0000);
    check("fault", 16'(fault_o), 16'h0001);
    status();
    check("hard err", 16'(rdata_o[ST_HARD_ERR]), 16'h0001);
    send(CMD_ERASE, 0);
    wait_on(1'b1, 400);
    check("erase on", 16'(erase_head_o), 16'h0001);
    $display("test track and error done");
    conclude();
  end
endmodule // testbench
